// ===== dv/dac_trigger_turbo_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dac_trigger_turbo_control_tb
	import dtt_pkg::*;
;
	typedef struct packed {logic [2:0] ch; logic [1:0] stp; logic [1:0] mul; logic [7:0] code;
		logic up; logic dn; logic [7:0] t;} dtt_row_t;
	typedef struct packed {logic [4:0] a; logic [7:0] rst; logic [7:0] w; logic [7:0] r;} dtt_reg_t;
	logic clk = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, rd_en = 1'b1, pwr = 1'b0, msk = 1'b0;
	logic sw = 1'b0, pin = 1'b0, rd_valid, soft_reset_bit, sclk, mv, up, dn;
	logic [4:0] rd_addr = 5'h00;
	logic [6:0] ev = 7'h00;
	logic [7:0] rd_data, t, f;
	logic [47:0] dac;
	dtt_wr_t wr_req = '0;
	dtt_msg_t msg;
	dtt_turbo_t [5:0] turbo;
	dtt_row_t r;
	int error_cnt = 0, compares = 0;
	dtt_reg_t regs [6] = '{'{5'h11, 8'h13, 8'hFF, 8'h13}, '{5'h12, 8'h15, 8'hFF, 8'h3F},
		'{5'h13, 8'h00, 8'h2A, 8'h2A}, '{5'h14, 8'h15, 8'h3F, 8'h3F}, '{5'h15, 8'h00, 8'hFF, 8'h3F},
		'{5'h1A, 8'h00, 8'h7F, 8'h00}};
	// turbo cases: channel, step, multiplier, new code, expected valids and time
	dtt_row_t rows [9] = '{'{0, 1, 0, 8'h40, 1, 0, 20}, '{0, 3, 0, 8'h2A, 0, 1, 18}, '{0, 1, 0, 8'h29, 0, 1, 14},
		'{0, 0, 1, 8'h20, 0, 1, 21}, '{5, 2, 0, 8'hB0, 1, 0, 77}, '{5, 3, 3, 8'h54, 0, 1, 45},
		'{5, 2, 2, 8'h28, 0, 1, 16}, '{3, 0, 0, 8'hF0, 1, 0, 33}, '{3, 0, 0, 8'hF0, 0, 0, 0}};
	always #2.5 clk = ~clk;
	dtt_host_model u_host (.clk_i(clk), .link_sclk_o(sclk), .msg_valid_o(mv), .msg_o(msg));
	dtt_core #(.NCH(6), .CW(8)) u_dut (.CLOCK_I(clk), .RESET_N_I(rst_n), .LINK_SCLK_I(sclk),
		.TRIGGER_PIN_I(pin), .WR_STROBE_I(wr_stb), .WR_REQ_I(wr_req), .RD_STROBE_I(rd_stb),
		.RD_ADDR_I(rd_addr), .READ_ENABLE_I(rd_en), .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data),
		.ERROR_EVENT_I(ev), .POWER_STARTUP_I(pwr), .SW_TRIGGER_I(sw), .SW_TRIGGER_MASKED_I(msk),
		.MSG_VALID_I(mv), .MSG_I(msg), .DAC_CODE_O(dac), .TURBO_O(turbo), .SOFT_RESET_O(soft_reset_bit));
	task automatic complete_run;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic u = 1'b1);
		@(negedge clk);
		wr_stb = 1'b1;
		wr_req = '{addr: a, data: d, usid: u};
		@(negedge clk);
		wr_stb = 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic v, input logic [7:0] exp);
		@(negedge clk);
		rd_stb = 1'b1;
		rd_addr = a;
		// the answer stands only in the cycle after the strobe edge
		@(posedge clk);
		#1;
		check("rd_valid", rd_valid, v);
		check("rd_data", rd_data, v ? exp : 8'h00);
		@(negedge clk);
		rd_stb = 1'b0;
	endtask
	// pin level or software trigger pulse, then settle time
	task automatic drive(input logic p, input logic s);
		@(negedge clk);
		pin = p;
		sw = s;
		@(negedge clk);
		sw = 1'b0;
		repeat (10) @(negedge clk);
	endtask
	initial
	begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
	initial
	begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		foreach (regs[i])
		begin
			rd(regs[i].a, 1'b1, regs[i].rst);
			wr(regs[i].a, regs[i].w);
			rd(regs[i].a, 1'b1, regs[i].r);
		end
		foreach (rows[i])
		begin
			r = rows[i];
			f = {2'b00, r.stp, r.stp, r.stp};
			wr(5'h12, f);
			wr(5'h14, f);
			f = {2'b00, r.mul, r.mul, r.mul};
			wr(5'h13, f);
			wr(5'h15, f);
			u_host.send_frame(r.ch, r.code);
			up = 1'b0;
			dn = 1'b0;
			t = 8'h00;
			@(negedge clk);
			sw = 1'b1;
			// turbo valids stand one cycle from the trigger edge itself
			repeat (12)
			begin
				@(posedge clk);
				#1;
				if (turbo[r.ch].up_valid === 1'b1)
				begin
					up = 1'b1;
					t = turbo[r.ch].up_time;
				end
				if (turbo[r.ch].down_valid === 1'b1)
				begin
					dn = 1'b1;
					t = turbo[r.ch].down_time;
				end
				@(negedge clk);
				sw = 1'b0;
			end
			check("up_valid", up, r.up);
			check("down_valid", dn, r.dn);
			check("turbo_time", t, r.t);
			check("dac_code", dac[r.ch*8+:8], r.code);
		end
		rd(5'h10, 1'b0, 8'h00);
		rd_en = 1'b0;
		rd(5'h12, 1'b0, 8'h00);
		rd(5'h1A, 1'b1, 8'h00);
		rd_en = 1'b1;
		@(negedge clk);
		ev = 7'h55;
		@(negedge clk);
		ev = 7'h00;
		rd(5'h1A, 1'b1, 8'h55);
		rd(5'h1A, 1'b1, 8'h00);
		@(negedge clk);
		ev = 7'h2A;
		@(negedge clk);
		ev = 7'h00;
		wr(5'h1A, 8'h7F);
		rd(5'h1A, 1'b1, 8'h2A);
		wr(5'h1A, 8'h80, 1'b0);
		rd(5'h12, 1'b1, 8'h00);
		wr(5'h1A, 8'h80);
		rd(5'h12, 1'b1, 8'h15);
		rd(5'h1A, 1'b1, 8'h00);
		wr(5'h13, 8'h2A);
		@(negedge clk);
		pwr = 1'b1;
		@(negedge clk);
		pwr = 1'b0;
		rd(5'h13, 1'b1, 8'h00);
		wr(5'h11, 8'h12);
		wr(5'h11, 8'h02);
		u_host.send_frame(3'd1, 8'h60);
		drive(1'b0, 1'b1);
		check("dac_code", dac[15:8], 8'h00);
		drive(1'b1, 1'b0);
		check("dac_code", dac[15:8], 8'h60);
		wr(5'h11, 8'h12);
		wr(5'h11, 8'h10);
		wr(5'h11, 8'h00);
		u_host.send_frame(3'd1, 8'h70);
		drive(1'b0, 1'b0);
		check("dac_code", dac[15:8], 8'h70);
		u_host.send_frame(3'd1, 8'h78);
		drive(1'b1, 1'b0);
		check("dac_code", dac[15:8], 8'h70);
		wr(5'h11, 8'h01);
		drive(1'b0, 1'b0);
		check("dac_code", dac[15:8], 8'h70);
		wr(5'h11, 8'h10);
		drive(1'b1, 1'b0);
		drive(1'b0, 1'b0);
		check("dac_code", dac[15:8], 8'h70);
		wr(5'h11, 8'h00);
		drive(1'b1, 1'b0);
		fork
			u_host.send_frame(3'd1, 8'h90);
			drive(1'b0, 1'b0);
		join
		check("dac_code", dac[15:8], 8'h78);
		drive(1'b1, 1'b0);
		drive(1'b0, 1'b0);
		check("dac_code", dac[15:8], 8'h90);
		@(negedge clk);
		rst_n = 1'b0;
		repeat (4) @(negedge clk);
		check("dac_code", dac[15:8], 8'h00);
		rst_n = 1'b1;
		rd(5'h11, 1'b1, 8'h13);
		// pin unused and software triggers masked: message applies at once
		@(negedge clk);
		msk = 1'b1;
		u_host.send_frame(3'd2, 8'h33);
		@(negedge clk);
		check("dac_code", dac[23:16], 8'h33);
		complete_run();
	end
endmodule
`default_nettype wire

// ===== dv/dtt_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// port checker for the trigger and turbo block
// ********
module dtt_core_monitor
	import dtt_pkg::*;
#(
	parameter int NCH = 6,
	parameter int CW = 8
)
(
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	// register access
	input wire logic WR_STROBE_I,
	input wire dtt_wr_t WR_REQ_I,
	input wire logic RD_STROBE_I,
	input wire logic [4:0] RD_ADDR_I,
	input wire logic READ_ENABLE_I,
	input wire logic RD_VALID_O,
	input wire logic [7:0] RD_DATA_O,
	// events and outputs
	input wire logic [6:0] ERROR_EVENT_I,
	input wire logic [NCH*CW-1:0] DAC_CODE_O,
	input wire dtt_turbo_t [NCH-1:0] TURBO_O,
	input wire logic SOFT_RESET_O
);
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RESET_N_I);
	logic rd_st; // status read
	logic rd_cfg; // config register read
	logic swr_wr; // soft reset bit written
	assign rd_st = RD_STROBE_I && RD_ADDR_I == 5'h1A;
	assign rd_cfg = RD_ADDR_I inside {[5'h11:5'h15]};
	assign swr_wr = WR_STROBE_I && WR_REQ_I.addr == 5'h1A && WR_REQ_I.data[7];
	a_read_answer: assert property (rd_st || RD_STROBE_I && READ_ENABLE_I && rd_cfg |=> RD_VALID_O)
		else $error("read not answered");
	a_read_refused: assert property (RD_STROBE_I && !rd_st && !(rd_cfg && READ_ENABLE_I) |=> !RD_VALID_O)
		else $error("refused read answered");
	a_swr_reads_zero: assert property (rd_st |=> RD_DATA_O[7] == 1'b0)
		else $error("soft reset bit read as one");
	a_flag_set: assert property (ERROR_EVENT_I != 7'h00 ##1 !RD_STROBE_I && !SOFT_RESET_O ##1 rd_st
		|=> (RD_DATA_O[6:0] & $past(ERROR_EVENT_I, 3)) == $past(ERROR_EVENT_I, 3))
		else $error("error flag not set");
	a_flag_clear: assert property (rd_st && ERROR_EVENT_I == 7'h00 ##1 ERROR_EVENT_I == 7'h00
		##1 rd_st && ERROR_EVENT_I == 7'h00 |=> RD_DATA_O[6:0] == 7'h00)
		else $error("flags not cleared by read");
	a_swr_usid_only: assert property (swr_wr && !WR_REQ_I.usid |-> !SOFT_RESET_O)
		else $error("soft reset from non unique id");
	a_swr_pulse: assert property (swr_wr && WR_REQ_I.usid |-> SOFT_RESET_O)
		else $error("soft reset write not accepted");
	a_swr_defaults: assert property (SOFT_RESET_O ##1 !WR_STROBE_I ##1 RD_STROBE_I && READ_ENABLE_I
		&& RD_ADDR_I == 5'h12 |=> RD_DATA_O == 8'h15)
		else $error("step register not restored");
	a_rd_idle: assert property (!RD_VALID_O |-> RD_DATA_O == 8'h00)
		else $error("read data without valid");
	for (genvar c = 0; c < NCH; c++)
	begin : g_ch
		a_turbo_up: assert property (TURBO_O[c].up_valid |-> DAC_CODE_O[c*CW+:CW] > $past(DAC_CODE_O[c*CW+:CW]))
			else $error("up turbo without rising code");
		a_turbo_down: assert property (TURBO_O[c].down_valid |-> !TURBO_O[c].up_valid
			&& DAC_CODE_O[c*CW+:CW] < $past(DAC_CODE_O[c*CW+:CW]))
			else $error("down turbo without falling code");
	end
endmodule
bind dtt_core dtt_core_monitor #(.NCH(NCH), .CW(CW)) u_mon (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I),
	.WR_STROBE_I(WR_STROBE_I), .WR_REQ_I(WR_REQ_I), .RD_STROBE_I(RD_STROBE_I), .RD_ADDR_I(RD_ADDR_I),
	.READ_ENABLE_I(READ_ENABLE_I), .RD_VALID_O(RD_VALID_O), .RD_DATA_O(RD_DATA_O),
	.ERROR_EVENT_I(ERROR_EVENT_I), .DAC_CODE_O(DAC_CODE_O), .TURBO_O(TURBO_O), .SOFT_RESET_O(SOFT_RESET_O));
`default_nettype wire

// ===== dv/dtt_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// serial bus master: link clock bursts and decoded messages
// ********
module dtt_host_model
	import dtt_pkg::*;
(
	// system clock
	input wire logic clk_i,
	// toward the device
	output logic link_sclk_o,
	output logic msg_valid_o,
	output dtt_msg_t msg_o
);
	// link clock idles low between frames
	initial
	begin
		link_sclk_o = 1'b0;
		msg_valid_o = 1'b0;
		msg_o = '0;
	end
	// one frame of eight link clocks, message ends with the last falling edge
	task automatic send_frame(input logic [2:0] chan, input logic [7:0] code);
		repeat (8)
		begin
			#32 link_sclk_o = 1'b1;
			#32 link_sclk_o = 1'b0;
		end
		@(negedge clk_i);
		msg_valid_o = 1'b1;
		msg_o = {chan, code};
		@(negedge clk_i);
		msg_valid_o = 1'b0;
		msg_o = ~msg_o; // released: not the last value
	endtask
endmodule
`default_nettype wire

// ===== rtl/dtt_cfg.svh
`ifndef DTT_CFG_SVH
`define DTT_CFG_SVH
// ************************************************************
// register offsets
// ************************************************************
`define DTT_ADDR_W 5
`define DTT_OFS_TRIGGER_PIN_CFG 5'h11
`define DTT_OFS_STEP_ABC 5'h12
`define DTT_OFS_MULT_ABC 5'h13
`define DTT_OFS_STEP_DEF 5'h14
`define DTT_OFS_MULT_DEF 5'h15
`define DTT_OFS_STATUS 5'h1A
// ************************************************************
// reset values and field positions
// ************************************************************
`define DTT_RST_TRIGGER_PIN_CFG 8'h13
`define DTT_RST_STEP 8'h15
`define DTT_RST_MULT 8'h00
`define DTT_RST_STATUS 8'h00
`define DTT_MASK_TRIGGER_PIN_CFG 8'h13
`define DTT_MASK_TURBO 8'h3F
`define DTT_MASK_FLAGS 8'h7F
`define DTT_BIT_SEL 4
`define DTT_BIT_EDGE 1
`define DTT_BIT_EXTMASK 0
`define DTT_BIT_SOFT_RESET 7
// ************************************************************
// timing and turbo arithmetic
// ************************************************************
`define DTT_CLK_NS 5
`define DTT_TRIGGER_SETTLE_LATENCY_MIN_NS 5
`define DTT_TRIGGER_SETTLE_LATENCY_MAX_NS 25
`define DTT_STEP_BASE_US 3
`define DTT_STEP_INC_US 2
`define DTT_MULT_MAX 4
`define DTT_HALF_LIMIT 21
`define DTT_IDX_MIN 2
`define DTT_IDX_MAX 11
`endif

// ===== rtl/dtt_core.sv
// Functional notes
// - pin edge applies message only after latency
// - pin selected: messages wait in shadow registers
// - software triggers ignored while pin selected
// - select one (reset) leaves pin unused
// - edge bit: zero falling, one rising
// - mask bit one masks pin trigger
// - step code picks 3/5/7/9 us
// - multiplier code picks factor 4/3/2/1
// - base delay index times step, 0-1 off
// - rising code gives up time base delay
// - falling low code adds multiplier term
// - falling high code gives base delay
// - four registers hold six step/multiplier pairs
// - por, soft reset, startup reset registers
// - status readable without read enable
// - status: soft reset bit7, flags 6..0
// - soft reset spares power mode, identifiers
// - flags set by hardware, clear on read
// - soft reset bit reads zero
// - soft reset only from unique id writes
`include "dtt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dtt_core
	import dtt_pkg::*;
#(
	parameter int NCH = 6,
	parameter int CW = 8
)
(
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	// serial link pins, asynchronous
	input wire logic LINK_SCLK_I,
	input wire logic TRIGGER_PIN_I,
	// register access from the frame decoder
	input wire logic WR_STROBE_I,
	input wire dtt_wr_t WR_REQ_I,
	input wire logic RD_STROBE_I,
	input wire logic [4:0] RD_ADDR_I,
	input wire logic READ_ENABLE_I,
	output logic RD_VALID_O,
	output logic [7:0] RD_DATA_O,
	// bus error events, one-cycle pulses
	input wire logic [6:0] ERROR_EVENT_I,
	// power mode and software trigger from the mode register
	input wire logic POWER_STARTUP_I,
	input wire logic SW_TRIGGER_I,
	input wire logic SW_TRIGGER_MASKED_I,
	// dac messages and outputs
	input wire logic MSG_VALID_I,
	input wire dtt_msg_t MSG_I,
	output logic [NCH*CW-1:0] DAC_CODE_O,
	output dtt_turbo_t [NCH-1:0] TURBO_O,
	output logic SOFT_RESET_O
);

	// ************************************************************
	// timing constants
	// ************************************************************
	// least latency rounds up, never below one cycle
	localparam int LAT_RAW = (`DTT_TRIGGER_SETTLE_LATENCY_MIN_NS + `DTT_CLK_NS - 1) / `DTT_CLK_NS;
	localparam int LAT_CYC = (LAT_RAW < 1) ? 1 : LAT_RAW;
	// longest latency rounds down, kept for reference
	localparam int LAT_MAX_CYC = `DTT_TRIGGER_SETTLE_LATENCY_MAX_NS / `DTT_CLK_NS;
	localparam logic [2:0] LAT_CNT = 3'(LAT_CYC);

	// ************************************************************
	// register state
	// ************************************************************
	logic [7:0] trigger_config; // select, edge, mask
	logic [7:0] turbo_step_abc; // step codes a..c
	logic [7:0] turbo_multiplier_abc; // multiplier codes a..c
	logic [7:0] turbo_step_def; // step codes d..f
	logic [7:0] turbo_multiplier_def; // multiplier codes d..f
	logic [6:0] bus_error_flags; // sticky error flags
	logic soft_reset_hit; // soft reset write seen
	logic sync_reset; // soft reset or startup reset, not the power-on reset
	logic wr_status; // write to status register
	logic rd_status; // accepted status read

	// soft reset only by unique id frames
	assign wr_status = WR_STROBE_I && (WR_REQ_I.addr == `DTT_OFS_STATUS);
	assign soft_reset_hit = wr_status && WR_REQ_I.usid && WR_REQ_I.data[`DTT_BIT_SOFT_RESET];
	// startup pass and soft reset restore the registers like power on, but not the shadows or outputs
	assign sync_reset = soft_reset_hit || POWER_STARTUP_I;
	assign SOFT_RESET_O = soft_reset_hit;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [1:0] sclk_sync; // link clock, two flops
	logic [1:0] trigger_pin_sync; // trigger pin, two flops
	logic sclk_last; // previous synced link clock
	logic trigger_pin_last; // previous synced trigger pin

	// two flops each, then one history stage
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			sclk_sync <= 2'h0;
			trigger_pin_sync <= 2'h0;
			sclk_last <= 1'h0;
			trigger_pin_last <= 1'h0;
		end
		else
		begin
			sclk_sync <= {sclk_sync[0], LINK_SCLK_I};
			trigger_pin_sync <= {trigger_pin_sync[0], TRIGGER_PIN_I};
			sclk_last <= sclk_sync[1];
			trigger_pin_last <= trigger_pin_sync[1];
		end
	end

	logic sclk_fall; // falling edge of link clock
	logic trigger_pin_rise; // rising edge of trigger pin
	logic trigger_pin_fall; // falling edge of trigger pin
	logic pin_edge; // selected active edge
	assign sclk_fall = sclk_last && !sclk_sync[1];
	assign trigger_pin_rise = !trigger_pin_last && trigger_pin_sync[1];
	assign trigger_pin_fall = trigger_pin_last && !trigger_pin_sync[1];
	// edge bit one means rising
	assign pin_edge = trigger_config[`DTT_BIT_EDGE] ? trigger_pin_rise : trigger_pin_fall;

	// ************************************************************
	// register writes
	// ************************************************************
	// trigger configuration, reserved bits held zero
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			trigger_config <= `DTT_RST_TRIGGER_PIN_CFG;
		else if (sync_reset)
			trigger_config <= `DTT_RST_TRIGGER_PIN_CFG;
		else if (WR_STROBE_I && WR_REQ_I.addr == `DTT_OFS_TRIGGER_PIN_CFG)
			trigger_config <= WR_REQ_I.data & `DTT_MASK_TRIGGER_PIN_CFG;
	end

	// turbo step and multiplier registers
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			turbo_step_abc <= `DTT_RST_STEP;
			turbo_multiplier_abc <= `DTT_RST_MULT;
			turbo_step_def <= `DTT_RST_STEP;
			turbo_multiplier_def <= `DTT_RST_MULT;
		end
		else if (sync_reset)
		begin
			turbo_step_abc <= `DTT_RST_STEP;
			turbo_multiplier_abc <= `DTT_RST_MULT;
			turbo_step_def <= `DTT_RST_STEP;
			turbo_multiplier_def <= `DTT_RST_MULT;
		end
		else if (WR_STROBE_I)
		begin
			// one register per write, reserved bits zero
			unique case (WR_REQ_I.addr)
				`DTT_OFS_STEP_ABC: turbo_step_abc <= WR_REQ_I.data & `DTT_MASK_TURBO;
				`DTT_OFS_MULT_ABC: turbo_multiplier_abc <= WR_REQ_I.data & `DTT_MASK_TURBO;
				`DTT_OFS_STEP_DEF: turbo_step_def <= WR_REQ_I.data & `DTT_MASK_TURBO;
				`DTT_OFS_MULT_DEF: turbo_multiplier_def <= WR_REQ_I.data & `DTT_MASK_TURBO;
				default:
				begin
				end
			endcase
		end
	end

	// ************************************************************
	// status flags
	// ************************************************************
	// a status read is always accepted
	assign rd_status = RD_STROBE_I && (RD_ADDR_I == `DTT_OFS_STATUS);

	// set by events, cleared by read, set wins; writes ignored
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			bus_error_flags <= 7'h00;
		else if (sync_reset)
			bus_error_flags <= ERROR_EVENT_I;
		else if (rd_status)
			bus_error_flags <= ERROR_EVENT_I;
		else
			bus_error_flags <= bus_error_flags | ERROR_EVENT_I;
	end

	// ************************************************************
	// register reads
	// ************************************************************
	logic [7:0] next_rd_data; // selected read value
	logic rd_hit; // mapped and permitted read

	// read mux, soft reset bit reads zero
	always_comb
	begin
		rd_hit = READ_ENABLE_I;
		unique case (RD_ADDR_I)
			`DTT_OFS_TRIGGER_PIN_CFG: next_rd_data = trigger_config;
			`DTT_OFS_STEP_ABC: next_rd_data = turbo_step_abc;
			`DTT_OFS_MULT_ABC: next_rd_data = turbo_multiplier_abc;
			`DTT_OFS_STEP_DEF: next_rd_data = turbo_step_def;
			`DTT_OFS_MULT_DEF: next_rd_data = turbo_multiplier_def;
			`DTT_OFS_STATUS:
			begin
				next_rd_data = {1'h0, bus_error_flags};
				rd_hit = 1'h1;
			end
			default:
			begin
				next_rd_data = 8'h00;
				rd_hit = 1'h0;
			end
		endcase
	end

	// registered read answer, one cycle after the strobe
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			RD_VALID_O <= 1'h0;
			RD_DATA_O <= 8'h00;
		end
		else
		begin
			RD_VALID_O <= RD_STROBE_I && rd_hit;
			RD_DATA_O <= (RD_STROBE_I && rd_hit) ? next_rd_data : 8'h00;
		end
	end

	// ************************************************************
	// message completion latency
	// ************************************************************
	logic [2:0] lat_count; // cycles since last link falling edge
	logic msg_pending; // message received, latency running
	logic msg_complete; // message now eligible for a trigger
	assign msg_complete = msg_pending && (lat_count >= LAT_CNT);

	// count from each falling link clock edge
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			lat_count <= 3'h0;
		else if (sclk_fall)
			lat_count <= 3'h0;
		else if (lat_count < LAT_CNT)
			lat_count <= lat_count + 3'h1;
	end

	// pending window from message to latency expiry
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			msg_pending <= 1'h0;
		else if (MSG_VALID_I)
			msg_pending <= 1'h1;
		else if (msg_complete)
			msg_pending <= 1'h0;
	end

	// ************************************************************
	// trigger selection
	// ************************************************************
	logic pin_selected; // external pin in use
	logic apply_trigger; // move completed shadows to outputs
	logic apply_direct; // no trigger, apply at once
	assign pin_selected = !trigger_config[`DTT_BIT_SEL];
	// pin path needs mask clear; software path only when pin unused
	assign apply_trigger = pin_selected ? (pin_edge && !trigger_config[`DTT_BIT_EXTMASK])
		: SW_TRIGGER_I;
	assign apply_direct = !pin_selected && SW_TRIGGER_MASKED_I;

	// ************************************************************
	// turbo arithmetic
	// ************************************************************
	// base delay in us, zero for index 0 and 1
	function automatic logic [7:0] base_delay(input logic [1:0] step_code, input logic [CW-1:0] code);
		logic [3:0] idx;
		logic [3:0] step;
		idx = (code[CW-1 -: 4] > 4'(`DTT_IDX_MAX)) ? 4'(`DTT_IDX_MAX) : code[CW-1 -: 4];
		step = 4'(`DTT_STEP_BASE_US) + 4'(`DTT_STEP_INC_US) * {2'h0, step_code};
		if (idx < 4'(`DTT_IDX_MIN))
			base_delay = 8'h00;
		else
			base_delay = 8'(idx * step);
	endfunction

	// down time with the low code correction term
	function automatic logic [7:0] down_delay(input logic [7:0] base, input logic [1:0] mult_code,
		input logic [CW-1:0] code);
		logic [CW-1:0] half;
		logic [2:0] factor;
		half = code >> 1;
		factor = 3'(`DTT_MULT_MAX) - {1'h0, mult_code};
		if (half < CW'(`DTT_HALF_LIMIT))
			down_delay = base + 8'(factor * (8'(`DTT_HALF_LIMIT) - 8'(half)));
		else
			down_delay = base;
	endfunction

	// ************************************************************
	// per output shadow, output and turbo
	// ************************************************************
	logic [11:0] step_all; // six step codes
	logic [11:0] mult_all; // six multiplier codes
	assign step_all = {turbo_step_def[5:0], turbo_step_abc[5:0]};
	assign mult_all = {turbo_multiplier_def[5:0], turbo_multiplier_abc[5:0]};

	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch++)
		begin : g_ch
			logic [CW-1:0] shadow_new; // latest received code
			logic new_valid; // shadow_new not yet eligible
			logic [CW-1:0] shadow_done; // last completed code
			logic done_valid; // completed code waiting
			logic [CW-1:0] out_code; // applied code
			logic load; // load output this cycle
			logic [CW-1:0] load_code; // code being loaded
			logic [7:0] base; // base delay of load
			logic msg_hit; // message for this output

			assign msg_hit = MSG_VALID_I && (MSG_I.chan == 3'(ch));

			// newest message waits here until complete
			always_ff @(posedge CLOCK_I or negedge RESET_N_I)
			begin
				if (!RESET_N_I)
				begin
					shadow_new <= '0;
					new_valid <= 1'h0;
				end
				else if (msg_hit)
				begin
					shadow_new <= MSG_I.code;
					new_valid <= 1'h1;
				end
				else if (msg_complete)
					new_valid <= 1'h0;
			end

			// only the last completed message survives
			always_ff @(posedge CLOCK_I or negedge RESET_N_I)
			begin
				if (!RESET_N_I)
				begin
					shadow_done <= '0;
					done_valid <= 1'h0;
				end
				else if (msg_complete && new_valid)
				begin
					shadow_done <= shadow_new;
					done_valid <= 1'h1;
				end
				else if (load)
					done_valid <= 1'h0;
			end

			// direct mode takes the raw message, else the completed shadow
			assign load = apply_direct ? msg_hit : (apply_trigger && done_valid);
			assign load_code = apply_direct ? MSG_I.code : shadow_done;
			assign base = base_delay(step_all[2*ch +: 2], load_code);

			// output code register
			always_ff @(posedge CLOCK_I or negedge RESET_N_I)
			begin
				if (!RESET_N_I)
					out_code <= '0;
				else if (load)
					out_code <= load_code;
			end

			// turbo result, valid for one cycle per load that changes the code
			always_ff @(posedge CLOCK_I or negedge RESET_N_I)
			begin
				if (!RESET_N_I)
					TURBO_O[ch] <= '0;
				else
				begin
					TURBO_O[ch].up_valid <= load && (load_code > out_code);
					TURBO_O[ch].down_valid <= load && (load_code < out_code);
					if (load && load_code > out_code)
						TURBO_O[ch].up_time <= base;
					if (load && load_code < out_code)
						TURBO_O[ch].down_time <= down_delay(base, mult_all[2*ch +: 2], load_code);
				end
			end

			assign DAC_CODE_O[ch*CW +: CW] = out_code;
		end
	endgenerate

endmodule
`default_nettype wire

// ===== rtl/dtt_pkg.sv
package dtt_pkg;
	// register write from the serial frame decoder
	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] data;
		logic usid;
	} dtt_wr_t;
	// completed dac message for one output
	typedef struct packed {
		logic [2:0] chan;
		logic [7:0] code;
	} dtt_msg_t;
	// turbo result for one output, times in microseconds
	typedef struct packed {
		logic up_valid;
		logic down_valid;
		logic [7:0] up_time;
		logic [7:0] down_time;
	} dtt_turbo_t;
endpackage
